// *** adc_clk_div.sv ***
`include "adc_params.svh"
// Converter clock enable from the base converter clock.
module adc_clk_div (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [2:0] divSel,
  output logic            convTick
);
  logic [3:0] count_reg;   // Cycle counter.
  logic [3:0] count_next;  // Next count.
  logic [3:0] limit;       // Terminal count for the selected ratio.

  // Ratio decode; bit 2 picks the by-three family, so with it low the spare code runs undivided.
  always_comb begin
    case (divSel)
      3'b000:  limit = 4'h3;
      3'b001:  limit = 4'h1;
      3'b010:  limit = 4'h0;
      3'b011:  limit = 4'h0;
      3'b100:  limit = 4'hB;
      3'b101:  limit = 4'h5;
      default: limit = 4'h2;
    endcase
    count_next = (count_reg >= limit) ? 4'h0 : count_reg + 4'h1;
    convTick   = (count_reg >= limit);
  end

  // Register the counter.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      count_reg <= 4'h0;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule : adc_clk_div

// *** adc_input_model.sv ***
// Analog pins and trigger source that face the sequencer.
module adc_input_model (
  input  wire logic       fire,
  input  wire logic [4:0] analogSel,
  output logic [9:0]      sampleCode,
  output logic            ext_trigger_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Each pin reads back as its own select code, so a wrong pin shows up.
  assign sampleCode = {analogSel, 5'h0B};
  // The pin idles high on its pull-up; a fire request pulls it low.
  assign ext_trigger_n = ~fire;
endmodule : adc_input_model

// *** adc_one_shot_control.sv ***
//Contract
// - Channel code 000..111 picks input 0..7.
// - Software trigger: go flag starts conversion.
// - External trigger: falling edge after go.
// - Stop at completion; software trigger clears go.
// - Writing go zero halts conversion.
// - Interrupt request at completion.
// - Result stored in selected pin's register.
// - One conversion per start.
// - Pin chosen from channel, group, amplifier.
// - Default, two alternate groups, two amplifier inputs.
// - Config rewrite mid-conversion gives undefined result.
// - Resolution bit selects 8 or 10 bits.
// - Sweep pin field ignored in one-shot.
// - Converter clock divider choices.
// - 49 or 59 cycles without hold.
// - 28 or 33 cycles with hold.
//
// Chosen here: register access over AXI4-Lite.
`include "adc_params.svh"
module adc_one_shot_control (
  input  wire logic        mclk,
  input  wire logic        reset,
  // AXI4-Lite slave.
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Converter side.
  input  wire logic        ext_trigger_n,
  input  wire logic [9:0]  sampleCode,
  output logic [4:0]       analogSel,
  output logic             sampling,
  output logic             vrefOn,
  output logic             convIrq
);
  // Software registers.
  logic [7:0]  ctl_reg, ctl_next;     // Control register.
  logic [7:0]  cfg_reg, cfg_next;     // Config register.
  logic [7:0]  cfg2_reg, cfg2_next;   // Config 2 register.
  logic [9:0]  res_reg [8];           // Result registers.
  logic [9:0]  res_next [8];          // Next result values.
  // Bus handshake state.
  logic        awHeld_reg, awHeld_next; // Write address captured.
  logic        wHeld_reg, wHeld_next;   // Write data captured.
  logic [11:0] awAddr_reg, awAddr_next;
  logic [31:0] wData_reg, wData_next;
  logic [3:0]  wStrb_reg, wStrb_next;
  logic        bValid_reg, bValid_next;
  logic [1:0]  bResp_reg, bResp_next;
  logic        rValid_reg, rValid_next;
  logic [1:0]  rResp_reg, rResp_next;
  logic [31:0] rData_reg, rData_next;
  // Sequencer state.
  adc_pkg::seq_state_t state_reg, state_next;
  logic [6:0]  cyc_reg, cyc_next;     // Converter cycles elapsed.
  logic        irq_reg, irq_next;     // Completion pulse.
  logic [4:0]  pin_reg, pin_next;     // Latched pin for this conversion.
  // Trigger pin synchroniser; the second stage and its one-cycle-later copy feed the edge detect.
  logic        trgMeta_reg, trgSync_reg, trgOld_reg;
  logic        convTick;              // Converter clock enable.
  logic        doWrite;               // Write commits this cycle.
  logic        fallEdge;              // Synchronised falling edge.
  logic [6:0]  convLen;               // Cycles for this conversion.
  logic [7:0]  wByte;                 // Write byte, lane 0.

  // Converter clock divider from the three divide bits.
  adc_clk_div u_div (
    .mclk     (mclk),
    .reset    (reset),
    .divSel   ({cfg2_reg[`ADC_F_DIV_B2], cfg_reg[`ADC_F_DIV_B1], ctl_reg[`ADC_F_DIV_B0]}),
    .convTick (convTick)
  );

  // Bus outputs; each ready is high while its own half holds nothing and no response of its kind is pending.
  assign s_axi_awready = !awHeld_reg && !bValid_reg;
  assign s_axi_wready  = !wHeld_reg && !bValid_reg;
  assign s_axi_arready = !rValid_reg;
  assign s_axi_bvalid  = bValid_reg;
  assign s_axi_bresp   = bResp_reg;
  assign s_axi_rvalid  = rValid_reg;
  assign s_axi_rresp   = rResp_reg;
  assign s_axi_rdata   = rData_reg;
  assign convIrq       = irq_reg;
  assign analogSel     = pin_reg;
  assign sampling      = (state_reg == adc_pkg::ST_CONV);
  assign vrefOn        = cfg_reg[`ADC_F_VREF];
  assign fallEdge      = trgOld_reg && !trgSync_reg;

  // Conversion length from resolution and hold setting.
  always_comb begin
    if (cfg2_reg[`ADC_F_SMP]) begin
      convLen = cfg_reg[`ADC_F_RES] ? `ADC_CYC_10_SH : `ADC_CYC_8_SH;
    end else begin
      convLen = cfg_reg[`ADC_F_RES] ? `ADC_CYC_10_PLAIN : `ADC_CYC_8_PLAIN;
    end
  end

  // Bus and register next-state logic, with the sequencer.
  always_comb begin
    awHeld_next = awHeld_reg;
    wHeld_next  = wHeld_reg;
    awAddr_next = awAddr_reg;
    wData_next  = wData_reg;
    wStrb_next  = wStrb_reg;
    bValid_next = bValid_reg;
    bResp_next  = bResp_reg;
    rValid_next = rValid_reg;
    rResp_next  = rResp_reg;
    rData_next  = rData_reg;
    ctl_next    = ctl_reg;
    cfg_next    = cfg_reg;
    cfg2_next   = cfg2_reg;
    res_next    = res_reg;
    state_next  = state_reg;
    cyc_next    = cyc_reg;
    irq_next    = 1'b0;
    pin_next    = pin_reg;
    wByte       = wData_reg[7:0];
    // Capture address and data in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      awHeld_next = 1'b1;
      awAddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeld_next = 1'b1;
      wData_next = s_axi_wdata;
      wStrb_next = s_axi_wstrb;
    end
    doWrite = awHeld_reg && wHeld_reg;
    // Commit a write once both halves are held.
    if (doWrite) begin
      awHeld_next = 1'b0;
      wHeld_next  = 1'b0;
      bValid_next = 1'b1;
      bResp_next  = 2'b00;
      if (wStrb_reg[0]) begin
        case ({awAddr_reg[11:2], 2'b00})
          `ADC_ADDR_CONTROL: ctl_next = wByte;
          `ADC_ADDR_CONFIG:  cfg_next = wByte;
          `ADC_ADDR_CONFIG2: cfg2_next = {3'b000, wByte[4:0]};
          default:           bResp_next = 2'b10;
        endcase
      end
    end
    if (bValid_reg && s_axi_bready) begin
      bValid_next = 1'b0;
    end
    // Reads; unmapped addresses answer SLVERR with zero data.
    if (s_axi_arvalid && s_axi_arready) begin
      rValid_next = 1'b1;
      rResp_next  = 2'b00;
      rData_next  = 32'h0000_0000;
      if ((s_axi_araddr & `ADC_RES_MASK) == `ADC_ADDR_RESULT0) begin
        rData_next = {22'h000000, res_reg[s_axi_araddr[`ADC_RES_IDX_LO +: 3]]};
      end else begin
        case ({s_axi_araddr[11:2], 2'b00})
          `ADC_ADDR_CONTROL: rData_next = {24'h000000, ctl_reg};
          `ADC_ADDR_CONFIG:  rData_next = {24'h000000, cfg_reg};
          `ADC_ADDR_CONFIG2: rData_next = {24'h000000, cfg2_reg};
          `ADC_ADDR_STATUS:  rData_next = {29'h00000000, state_reg};
          default:           rResp_next = 2'b10;
        endcase
      end
    end
    if (rValid_reg && s_axi_rready) begin
      rValid_next = 1'b0;
    end
    // Sequencer; sweep pin bits are never consulted here.
    case (state_reg)
      adc_pkg::ST_IDLE: begin
        // Start only on a rising go write.
        if (ctl_next[`ADC_F_GO] && !ctl_reg[`ADC_F_GO]) begin
          // Pin: group bits form the top, amplifier bits pick the extras.
          if (cfg_reg[`ADC_F_OPA_HI] && !cfg_reg[`ADC_F_OPA_LO]) begin
            // Amplifier inputs take group code 01 with channel 0 or 1, so they alias pins 8 and 9 of that group.
            pin_next = {4'h4, ctl_next[`ADC_F_CHAN_LO]};
          end else begin
            pin_next = {cfg2_reg[`ADC_F_GRP_LO +: 2], ctl_next[`ADC_F_CHAN_LO +: 3]};
          end
          cyc_next = 7'd0;
          if (ctl_next[`ADC_F_TRIG_SRC]) begin
            state_next = adc_pkg::ST_ARM;
          end else begin
            state_next = adc_pkg::ST_CONV;
          end
        end
      end
      adc_pkg::ST_ARM: begin
        if (!ctl_next[`ADC_F_GO]) begin
          state_next = adc_pkg::ST_IDLE;
        end else if (fallEdge) begin
          state_next = adc_pkg::ST_CONV;
        end
      end
      adc_pkg::ST_CONV: begin
        if (!ctl_next[`ADC_F_GO]) begin
          state_next = adc_pkg::ST_IDLE;
        end else if (convTick) begin
          if (cyc_reg + 7'd1 >= convLen) begin
            // Single result, then stop.
            state_next = adc_pkg::ST_IDLE;
            irq_next   = 1'b1;
            res_next[pin_reg[2:0]] = cfg_reg[`ADC_F_RES] ? sampleCode
                                                         : {2'b00, sampleCode[9:2]};
            if (!ctl_reg[`ADC_F_TRIG_SRC]) begin
              ctl_next[`ADC_F_GO] = 1'b0;
            end
          end else begin
            cyc_next = cyc_reg + 7'd1;
          end
        end
      end
      default: state_next = adc_pkg::ST_IDLE;
    endcase
  end

  // Register everything; trigger pin passes two stages first.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctl_reg     <= `ADC_RST_CONTROL;
      cfg_reg     <= `ADC_RST_CONFIG;
      cfg2_reg    <= `ADC_RST_CONFIG2;
      for (int i = 0; i < 8; i++) begin
        res_reg[i] <= 10'h000;
      end
      awHeld_reg  <= 1'b0;
      wHeld_reg   <= 1'b0;
      awAddr_reg  <= 12'h000;
      wData_reg   <= 32'h0000_0000;
      wStrb_reg   <= 4'h0;
      bValid_reg  <= 1'b0;
      bResp_reg   <= 2'b00;
      rValid_reg  <= 1'b0;
      rResp_reg   <= 2'b00;
      rData_reg   <= 32'h0000_0000;
      state_reg   <= adc_pkg::ST_IDLE;
      cyc_reg     <= 7'd0;
      irq_reg     <= 1'b0;
      pin_reg     <= 5'h00;
      trgMeta_reg <= 1'b1;
      trgSync_reg <= 1'b1;
      trgOld_reg  <= 1'b1;
    end else begin
      ctl_reg     <= ctl_next;
      cfg_reg     <= cfg_next;
      cfg2_reg    <= cfg2_next;
      res_reg     <= res_next;
      awHeld_reg  <= awHeld_next;
      wHeld_reg   <= wHeld_next;
      awAddr_reg  <= awAddr_next;
      wData_reg   <= wData_next;
      wStrb_reg   <= wStrb_next;
      bValid_reg  <= bValid_next;
      bResp_reg   <= bResp_next;
      rValid_reg  <= rValid_next;
      rResp_reg   <= rResp_next;
      rData_reg   <= rData_next;
      state_reg   <= state_next;
      cyc_reg     <= cyc_next;
      irq_reg     <= irq_next;
      pin_reg     <= pin_next;
      trgMeta_reg <= ext_trigger_n;
      trgSync_reg <= trgMeta_reg;
      trgOld_reg  <= trgSync_reg;
    end
  end
endmodule : adc_one_shot_control

// *** adc_one_shot_control_props.sv ***
`include "adc_params.svh"
// Watches the register bus and the converter outputs of the one-shot sequencer.
module adc_one_shot_control_props (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sampling,
  input  wire logic        vrefOn,
  input  wire logic        convIrq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic [11:0] wAddr_reg, wAddr_next;     // Address of the write under way.
  logic        wVref_reg, wVref_next;     // Reference bit of that write.
  logic        wLane_reg, wLane_next;     // Byte lane 0 was enabled.
  logic [15:0] convCnt_reg, convCnt_next; // Cycles spent converting so far.
  // Capture each write half as it is taken, since either may come first.
  always_comb begin
    wAddr_next = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : wAddr_reg;
    wVref_next = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata[5] : wVref_reg;
    wLane_next = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb[0] : wLane_reg;
    convCnt_next = sampling ? convCnt_reg + 16'h0001 : 16'h0000;
  end
  // Registers only; the counter keeps long waits out of the properties.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wAddr_reg   <= 12'h000;
      wVref_reg   <= 1'b0;
      wLane_reg   <= 1'b0;
      convCnt_reg <= 16'h0000;
    end else begin
      wAddr_reg   <= wAddr_next;
      wVref_reg   <= wVref_next;
      wLane_reg   <= wLane_next;
      convCnt_reg <= convCnt_next;
    end
  end
  sequence sIrqPulse;
    convIrq ##1 !convIrq;
  endsequence
  a_irq_one_pulse: assert property ($rose(convIrq) |-> sIrqPulse)
    else $error("interrupt pulse longer than one cycle");
  a_irq_ends_conv: assert property ($rose(convIrq) |-> $past(sampling) && !sampling)
    else $error("interrupt not at end of conversion");
  // The slowest case is 59 ticks at divide-by-12, so 720 cycles is a safe ceiling.
  a_conv_bounded: assert property (sampling |-> convCnt_reg < 16'h02D0)
    else $error("conversion runs too long");
  a_vref_follows: assert property ($rose(s_axi_bvalid) && wLane_reg
    && wAddr_reg == `ADC_ADDR_CONFIG |=> vrefOn == wVref_reg)
    else $error("reference output does not follow config write");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped early");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
endmodule : adc_one_shot_control_props
bind adc_one_shot_control adc_one_shot_control_props u_props (.*);

// *** adc_params.svh ***
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH
// Register indices; a register's bus byte address is four times its index.
`define ADC_OFS_CONTROL  12'h3D6
`define ADC_OFS_CONFIG   12'h3D7
`define ADC_OFS_CONFIG2  12'h3D4
`define ADC_OFS_RESULT0  12'h3C0
`define ADC_OFS_STATUS   12'h3E0
// Bus byte addresses, one aligned word each; result n sits eight times n above result 0.
`define ADC_ADDR_CONTROL 12'hF58
`define ADC_ADDR_CONFIG  12'hF5C
`define ADC_ADDR_CONFIG2 12'hF50
`define ADC_ADDR_RESULT0 12'hF00
`define ADC_ADDR_STATUS  12'hF80
// Result window match mask, and the lowest address bit of the result index.
`define ADC_RES_MASK     12'hFC7
`define ADC_RES_IDX_LO   3
// Reset values.
`define ADC_RST_CONTROL  8'h00
`define ADC_RST_CONFIG   8'h00
`define ADC_RST_CONFIG2  8'h00
// Control register fields.
`define ADC_F_CHAN_LO    0
`define ADC_F_MODE_LO    3
`define ADC_F_TRIG_SRC   5
`define ADC_F_GO         6
`define ADC_F_DIV_B0     7
// Config register fields.
`define ADC_F_OPA_LO     6
`define ADC_F_MODE1      2
`define ADC_F_RES        3
`define ADC_F_DIV_B1     4
`define ADC_F_VREF       5
`define ADC_F_OPA_HI     7
// Config 2 register fields.
`define ADC_F_SMP        0
`define ADC_F_GRP_LO     1
`define ADC_F_DIV_B2     4
// Conversion lengths in converter clock cycles.
`define ADC_CYC_8_PLAIN  7'd49
`define ADC_CYC_10_PLAIN 7'd59
`define ADC_CYC_8_SH     7'd28
`define ADC_CYC_10_SH    7'd33
`endif

// *** adc_pkg.sv ***
package adc_pkg;
  // Sequencer states, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARM  = 3'b010,
    ST_CONV = 3'b100
  } seq_state_t;
endpackage : adc_pkg

// *** test_adc_one_shot_control.sv ***
`include "adc_params.svh"
// Drives the sequencer over its register bus and checks what it converts.
module test_adc_one_shot_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0, reset = 1'b1, fire = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rv;
  logic [9:0]  sampleCode;
  logic [4:0]  analogSel;
  logic        ext_trigger_n, sampling, vrefOn, convIrq, irq;
  int          n_mismatch = 0, cmp_count = 0, len, i, convRun = 0;
  int          lens[4] = '{49, 59, 28, 33}; // Indexed by {hold, resolution}.
  always #2 mclk = ~mclk;
  // Converting cycles seen at the falling edges so far; zero while idle.
  always @(negedge mclk) convRun <= sampling ? convRun + 1 : 0;
  adc_one_shot_control u_adc_one_shot_control (.*);
  adc_input_model u_adc_input_model (.*);
  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  // Handshakes are judged at the falling edge, where the rising edge's view is settled.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic awH, wH, bH;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(negedge mclk);
      awH = s_axi_awvalid && s_axi_awready;
      wH = s_axi_wvalid && s_axi_wready;
      bH = s_axi_bvalid;
      @(posedge mclk);
      if (awH) s_axi_awvalid <= 1'b0;
      if (wH) s_axi_wvalid <= 1'b0;
      if (bH) begin
        s_axi_bready <= 1'b0;
        @(posedge mclk);
        return;
      end
    end
    n_mismatch++;
    results();
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic arH, rH;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(negedge mclk);
      arH = s_axi_arvalid && s_axi_arready;
      rH = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      if (arH) s_axi_arvalid <= 1'b0;
      if (rH) begin
        s_axi_rready <= 1'b0;
        @(posedge mclk);
        return;
      end
    end
    n_mismatch++;
    results();
  endtask : rd
  // Counts converting cycles until the interrupt pulse, or gives up.
  task automatic waitIrq(input int lim, output int n, output logic seen);
    n = 0;
    seen = 1'b0;
    for (int k = 0; k < lim && !seen; k++) begin
      @(negedge mclk);
      n = convRun;
      seen = convIrq;
    end
    @(posedge mclk);
  endtask : waitIrq
  // A low pulse long enough to pass the pin synchroniser.
  task automatic pulse();
    fire <= 1'b1;
    cyc(4);
    fire <= 1'b0;
    cyc(4);
  endtask : pulse
  initial begin
    cyc(4);
    reset <= 1'b0;
    @(posedge mclk);
    // All three settings registers come up zero; an unmapped place is refused.
    rd(`ADC_ADDR_CONTROL, rv, rr); chk(rv, 32'h0);
    rd(`ADC_ADDR_CONFIG, rv, rr); chk(rv, 32'h0);
    rd(`ADC_ADDR_CONFIG2, rv, rr); chk(rv, 32'h0);
    rd(12'h100, rv, rr); chk({30'h0, rr}, 32'h2);
    // A write with byte lane 0 disabled leaves the register alone.
    s_axi_wstrb <= 4'h0; wr(`ADC_ADDR_CONFIG, 32'hFF); s_axi_wstrb <= 4'hF;
    rd(`ADC_ADDR_CONFIG, rv, rr); chk(rv, 32'h0);
    $display("Test reset values done");
    // The pin is latched at start, so each pick is started and then halted.
    for (i = 0; i < 8; i++) begin
      wr(`ADC_ADDR_CONTROL, 32'h40 | i); cyc(2); chk({27'h0, analogSel}, i);
      wr(`ADC_ADDR_CONTROL, i);
    end
    // Alternate group two moves the pick into the upper bank.
    wr(`ADC_ADDR_CONFIG2, 32'h04); wr(`ADC_ADDR_CONTROL, 32'h43); cyc(2);
    chk({27'h0, analogSel}, 32'h13);
    wr(`ADC_ADDR_CONTROL, 32'h03);
    // Amplifier connection picks extended input 1 from channel bit 0.
    wr(`ADC_ADDR_CONFIG, 32'h80); wr(`ADC_ADDR_CONTROL, 32'h41); cyc(2);
    chk({27'h0, analogSel}, 32'h09);
    wr(`ADC_ADDR_CONTROL, 32'h01);
    $display("Test pin select done");
    // Every resolution and hold choice, converter clock undivided.
    for (i = 0; i < 4; i++) begin
      wr(`ADC_ADDR_CONFIG, 32'h30 | ((i & 1) << 3));
      wr(`ADC_ADDR_CONFIG2, 32'h04 | (i >> 1));
      wr(`ADC_ADDR_CONTROL, 32'h00);
      cyc(250);
      wr(`ADC_ADDR_CONTROL, 32'h40);
      waitIrq(1000, len, irq); chk({31'h0, irq}, 32'h1);
      chk(len, lens[i]);
      rd(`ADC_ADDR_CONTROL, rv, rr); chk({31'h0, rv[6]}, 32'h0);
      rd(`ADC_ADDR_RESULT0, rv, rr); chk({22'h0, rv[9:0]}, (i & 1) ? 32'h20B : 32'h82);
    end
    // Divide-by-12 on channel 5, with the sweep bits, config bits 0 and 1, set.
    wr(`ADC_ADDR_CONFIG, 32'h23); wr(`ADC_ADDR_CONFIG2, 32'h10);
    wr(`ADC_ADDR_CONTROL, 32'h45);
    waitIrq(1000, len, irq); chk({31'h0, irq}, 32'h1);
    chk({31'h0, len > lens[0] * 12 - 12 && len <= lens[0] * 12}, 32'h1);
    rd(`ADC_ADDR_RESULT0 + 12'h028, rv, rr); chk(rv, 32'h2A);
    $display("Test software conversions done");
    // Halting midway gives no interrupt and no further converting.
    wr(`ADC_ADDR_CONTROL, 32'h40); cyc(5); wr(`ADC_ADDR_CONTROL, 32'h00); cyc(2);
    chk({31'h0, sampling}, 32'h0);
    waitIrq(100, len, irq); chk({31'h0, irq}, 32'h0);
    $display("Test halt done");
    // External trigger: nothing until the falling edge, once only.
    wr(`ADC_ADDR_CONTROL, 32'h20); wr(`ADC_ADDR_CONTROL, 32'h60); cyc(20);
    chk({31'h0, sampling}, 32'h0);
    pulse();
    waitIrq(1000, len, irq); chk({31'h0, irq}, 32'h1);
    rd(`ADC_ADDR_CONTROL, rv, rr); chk({31'h0, rv[6]}, 32'h1);
    pulse(); chk({31'h0, sampling}, 32'h0);
    $display("Test external trigger done");
    results();
  end
endmodule : test_adc_one_shot_control
